// ---- core/mer_defs.vh ----
// Register offsets, field positions and reset values of the result bank
`ifndef MER_DEFS_VH
`define MER_DEFS_VH
`define MER_OFF_SM4_EVENTS   8'h23
`define MER_OFF_SM5_EVENTS   8'h24
`define MER_OFF_SM6_EVENTS   8'h25
`define MER_OFF_SM7_EVENTS   8'h26
`define MER_OFF_SM8_EVENTS   8'h27
`define MER_OFF_COUNT_LOW    8'h28
`define MER_OFF_COUNT_HIGH   8'h29
`define MER_OFF_PEDO_SRC     8'h2A
`define MER_OFF_INIT_REQ     8'h2C
`define MER_OFF_DELTA_LOW    8'hAA
`define MER_OFF_DELTA_HIGH   8'hAB
`define MER_OFF_ACCESS_CFG   8'h3F
`define MER_ADDR_W           8
`define MER_SRC_RST_BIT      7
`define MER_SRC_DET_BIT      5
`define MER_SRC_WIN_BIT      4
`define MER_SRC_OVF_BIT      3
`define MER_SRC_INC_BIT      2
`define MER_SRC_WR_MASK      8'h80
`define MER_INIT_LC_BIT      7
`define MER_INIT_SM_BIT      5
`define MER_INIT_TILT_BIT    4
`define MER_INIT_PEDO_BIT    3
`define MER_INIT_WR_MASK     8'hB8
`define MER_ACC_EN_BIT       7
`define MER_ACC_WR_MASK      8'h80
`define MER_ZERO8            8'h00
`define MER_ZERO16           16'h0000
`define MER_ONE16            16'h0001
`define MER_ALL16            16'hFFFF
`define MER_ZERO32           32'h0000_0000
`endif

// ---- core/mer_result_regs.v ----
// APB register bank for motion engine results and init requests
// Functional notes
// - Read-only state machine four events at 23h
// - Read-only state machine five events at 24h
// - Read-only state machine six events at 25h
// - Read-only state machine seven events at 26h
// - Read-only state machine eight events at 27h
// - Event flag reads one when detected
// - Step count low at 28h, high 29h
// - Top bit of 2Ah resets step counter
// - Step detected bit shows detection event
// - Window bit shows steps in delta time
// - Overflow bit set when count reaches 2^16
// - Increment bit set when count increases
// - Nonzero delta period keeps increment bit zero
// - Init bit for early learning core
// - Init bit for significant motion
// - Init bit for tilt algorithm
// - Init bit for pedometer algorithm
`timescale 1ns/10ps
`include "mer_defs.vh"

module mer_result_regs (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output wire        pslverr_o,
  input  wire [7:0]  sm4_events_i,
  input  wire [7:0]  sm5_events_i,
  input  wire [7:0]  sm6_events_i,
  input  wire [7:0]  sm7_events_i,
  input  wire [7:0]  sm8_events_i,
  input  wire        step_pulse_i,
  input  wire        step_detected_i,
  input  wire        steps_in_window_i,
  output wire        step_count_reset_o,
  output reg         learning_core_early_init_o,
  output reg         significant_motion_init_o,
  output reg         tilt_init_o,
  output reg         pedometer_algo_init_o,
  output wire        embedded_page_access_enable_o
);

  reg  [7:0]  sm_events [0:4];
  reg  [15:0] step_count;
  reg         overflow_flag;
  reg         count_increment_flag;
  reg         detected_flag;
  reg         window_flag;
  reg  [7:0]  pedo_src_ctrl;
  reg  [7:0]  delta_low;
  reg  [7:0]  delta_high;
  reg  [7:0]  access_configuration;
  reg  [7:0]  rd_byte;
  reg         rd_hit;
  reg  [7:0]  next_init;
  reg  [7:0]  init_pending;

  wire [7:0]  word_off;
  wire        aligned;
  wire        wr_en;
  wire        rd_en;
  wire        delta_zero;
  wire        count_run;

  // Registers sit one per aligned word: byte address is offset times four
  assign word_off  = paddr_i[9:2];
  assign aligned   = (paddr_i[1:0] == 2'b00) && (paddr_i[31:10] == 22'd0);
  assign wr_en     = psel_i && penable_i && pwrite_i && pstrb_i[0];
  assign rd_en     = psel_i && penable_i && !pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !(aligned && rd_hit);

  assign step_count_reset_o = pedo_src_ctrl[`MER_SRC_RST_BIT];
  assign embedded_page_access_enable_o =
    access_configuration[`MER_ACC_EN_BIT];
  assign delta_zero = ({delta_high, delta_low} == `MER_ZERO16);
  // Counting halts while reset is held; the overflowed count sticks at max
  assign count_run  = step_pulse_i && !step_count_reset_o && !overflow_flag;

  // Event registers track the state machines' live outputs
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sm_events[0] <= `MER_ZERO8;
      sm_events[1] <= `MER_ZERO8;
      sm_events[2] <= `MER_ZERO8;
      sm_events[3] <= `MER_ZERO8;
      sm_events[4] <= `MER_ZERO8;
    end else begin
      sm_events[0] <= sm4_events_i;
      sm_events[1] <= sm5_events_i;
      sm_events[2] <= sm6_events_i;
      sm_events[3] <= sm7_events_i;
      sm_events[4] <= sm8_events_i;
    end
  end

  // Step counter and pedometer status
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      step_count           <= `MER_ZERO16;
      overflow_flag        <= 1'b0;
      count_increment_flag <= 1'b0;
      detected_flag        <= 1'b0;
      window_flag          <= 1'b0;
    end else begin
      detected_flag <= step_detected_i;
      window_flag   <= steps_in_window_i;
      if (step_count_reset_o) begin
        step_count    <= `MER_ZERO16;
        overflow_flag <= 1'b0;
      end else if (count_run) begin
        // A step at all ones is the point where 2^16 is reached; the count holds at all ones
        if (step_count == `MER_ALL16) begin
          overflow_flag <= 1'b1;
        end else begin
          step_count <= step_count + `MER_ONE16;
        end
      end
      // Flag mirrors the increase; a window period suppresses it
      count_increment_flag <= count_run && delta_zero;
    end
  end

  // Writable control registers; reserved bits are masked off on write
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      pedo_src_ctrl        <= `MER_ZERO8;
      delta_low            <= `MER_ZERO8;
      delta_high           <= `MER_ZERO8;
      access_configuration <= `MER_ZERO8;
      init_pending         <= `MER_ZERO8;
    end else begin
      init_pending <= `MER_ZERO8;
      if (wr_en && aligned) begin
        case (word_off)
          `MER_OFF_PEDO_SRC:
            pedo_src_ctrl <= pwdata_i[7:0] & `MER_SRC_WR_MASK;
          `MER_OFF_INIT_REQ:
            init_pending <= pwdata_i[7:0] & `MER_INIT_WR_MASK;
          `MER_OFF_DELTA_LOW:
            delta_low <= pwdata_i[7:0];
          `MER_OFF_DELTA_HIGH:
            delta_high <= pwdata_i[7:0];
          `MER_OFF_ACCESS_CFG:
            access_configuration <= pwdata_i[7:0] & `MER_ACC_WR_MASK;
          default: begin
          end
        endcase
      end
    end
  end

  // One-shot init strobes, one cycle after the write; register reads zero
  always @* begin
    next_init = init_pending;
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      learning_core_early_init_o <= 1'b0;
      significant_motion_init_o  <= 1'b0;
      tilt_init_o                <= 1'b0;
      pedometer_algo_init_o      <= 1'b0;
    end else begin
      learning_core_early_init_o <= next_init[`MER_INIT_LC_BIT];
      significant_motion_init_o  <= next_init[`MER_INIT_SM_BIT];
      tilt_init_o                <= next_init[`MER_INIT_TILT_BIT];
      pedometer_algo_init_o      <= next_init[`MER_INIT_PEDO_BIT];
    end
  end

  // Read decode
  always @* begin
    rd_byte = `MER_ZERO8;
    rd_hit  = 1'b1;
    case (word_off)
      `MER_OFF_SM4_EVENTS: rd_byte = sm_events[0];
      `MER_OFF_SM5_EVENTS: rd_byte = sm_events[1];
      `MER_OFF_SM6_EVENTS: rd_byte = sm_events[2];
      `MER_OFF_SM7_EVENTS: rd_byte = sm_events[3];
      `MER_OFF_SM8_EVENTS: rd_byte = sm_events[4];
      `MER_OFF_COUNT_LOW:  rd_byte = step_count[7:0];
      `MER_OFF_COUNT_HIGH: rd_byte = step_count[15:8];
      `MER_OFF_PEDO_SRC: begin
        rd_byte = pedo_src_ctrl;
        rd_byte[`MER_SRC_DET_BIT] = detected_flag;
        rd_byte[`MER_SRC_WIN_BIT] = window_flag;
        rd_byte[`MER_SRC_OVF_BIT] = overflow_flag;
        rd_byte[`MER_SRC_INC_BIT] = count_increment_flag;
      end
      `MER_OFF_INIT_REQ:   rd_byte = `MER_ZERO8;
      `MER_OFF_DELTA_LOW:  rd_byte = delta_low;
      `MER_OFF_DELTA_HIGH: rd_byte = delta_high;
      `MER_OFF_ACCESS_CFG: rd_byte = access_configuration;
      default:             rd_hit  = 1'b0;
    endcase
  end

  // Read data registered at the setup edge, held until the next read
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      prdata_o <= `MER_ZERO32;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= {24'd0, (aligned && rd_hit) ? rd_byte : `MER_ZERO8};
    end
  end

endmodule // mer_result_regs

// ---- tb/mer_result_regs_props.sv ----
// Concurrent checks on the result register bank ports
`timescale 1ns/10ps
module mer_props (
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0]  pstrb_i,
  input wire [31:0] prdata_o,
  input wire [7:0]  sm4_events_i,
  input wire [7:0]  sm8_events_i,
  input wire        step_count_reset_o,
  input wire        learning_core_early_init_o,
  input wire        significant_motion_init_o,
  input wire        tilt_init_o,
  input wire        pedometer_algo_init_o
);
  wire rd_set = psel_i && !penable_i && !pwrite_i;
  wire wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
  wire wr_init = wr && paddr_i == 32'h0000_00B0;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_sm4;
    rd_set && paddr_i == 32'h0000_008C |=>
      prdata_o == {24'h00_0000, $past(sm4_events_i)};
  endproperty
  a_sm4: assert property (p_sm4) else $error("sm4 read wrong");
  property p_sm8;
    rd_set && paddr_i == 32'h0000_009C |=> prdata_o[7:0] == $past(sm8_events_i);
  endproperty
  a_sm8: assert property (p_sm8) else $error("sm8 read wrong");
  property p_rst_bit;
    wr && paddr_i == 32'h0000_00A8 |=> step_count_reset_o == $past(pwdata_i[7]);
  endproperty
  a_rst_bit: assert property (p_rst_bit) else $error("reset bit");
  property p_lc;
    wr_init && pwdata_i[7] |-> ##[1:2] learning_core_early_init_o;
  endproperty
  a_lc: assert property (p_lc) else $error("core init missing");
  property p_sig;
    wr_init && pwdata_i[5] |-> ##[1:2] significant_motion_init_o;
  endproperty
  a_sig: assert property (p_sig) else $error("motion init missing");
  property p_tilt;
    wr_init && pwdata_i[4] |-> ##[1:2] tilt_init_o;
  endproperty
  a_tilt: assert property (p_tilt) else $error("tilt init missing");
  property p_pedo;
    wr_init && pwdata_i[3] |-> ##[1:2] pedometer_algo_init_o ##1 !pedometer_algo_init_o;
  endproperty
  a_pedo: assert property (p_pedo) else $error("pedo init pulse");
  property p_shot;
    tilt_init_o |-> !$past(tilt_init_o) && ($past(wr_init) || $past(wr_init, 2));
  endproperty
  a_shot: assert property (p_shot) else $error("stray init pulse");
endmodule // mer_props
bind mer_result_regs mer_props mer_props_inst (.clk_sys_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
  .sm4_events_i, .sm8_events_i, .step_count_reset_o,
  .learning_core_early_init_o, .significant_motion_init_o, .tilt_init_o,
  .pedometer_algo_init_o);

// ---- tb/tb_top.sv ----
// Self-checking bench for the result register bank
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys_i = 0, rst_i = 1, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, step_pulse_i = 0;
  logic        step_detected_i = 0, steps_in_window_i = 0;
  logic [31:0] paddr_i = '0, pwdata_i = '0;
  logic [3:0]  pstrb_i = 4'hF;
  logic [7:0]  ev [5] = '{8'h81, 8'h42, 8'h24, 8'h18, 8'hFF};
  wire  [7:0]  sm4_events_i = ev[0], sm5_events_i = ev[1];
  wire  [7:0]  sm6_events_i = ev[2], sm7_events_i = ev[3];
  wire  [7:0]  sm8_events_i = ev[4];
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, step_count_reset_o, tilt_init_o;
  wire         learning_core_early_init_o, significant_motion_init_o;
  wire         pedometer_algo_init_o, embedded_page_access_enable_o;
  logic [7:0]  rd;
  logic        er;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  mer_result_regs mer_result_regs_inst (.clk_sys_i, .rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pready_o,
    .prdata_o, .pslverr_o, .sm4_events_i, .sm5_events_i, .sm6_events_i,
    .sm7_events_i, .sm8_events_i, .step_pulse_i, .step_detected_i,
    .steps_in_window_i, .step_count_reset_o, .learning_core_early_init_o,
    .significant_motion_init_o, .tilt_init_o, .pedometer_algo_init_o,
    .embedded_page_access_enable_o);
  initial forever #20 clk_sys_i = ~clk_sys_i;
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Overflow run alone needs 65536 cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      final_report();
    end
  end
  // Idle edge first, so a release never meets the next setup
  task apb(input logic w, input logic [7:0] off, input logic [7:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= {22'h00_0000, off, 2'b00};
    pwdata_i <= 32'(d);
    @(posedge clk_sys_i);
    penable_i <= 1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) @(posedge clk_sys_i);
    rd = prdata_o[7:0];
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task rchk(input string nm, input logic [7:0] off, input logic [7:0] e);
    apb(0, off, 8'h00);
    chk(nm, e, rd);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 0;
    apb(1, 8'h3F, 8'h80);
    // The write lands at the access edge; look once it has settled
    @(posedge clk_sys_i);
    chk("page_en", 8'h01, {7'h00, embedded_page_access_enable_o});
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h23 + i, ~ev[i]);
      rchk("events", 8'h23 + i, ev[i]);
    end
    step_detected_i <= 1;
    steps_in_window_i <= 1;
    repeat (6) @(posedge clk_sys_i) step_pulse_i <= ~step_pulse_i;
    repeat (3) @(posedge clk_sys_i);
    rchk("count_lo", 8'h28, 8'h03);
    rchk("count_hi", 8'h29, 8'h00);
    rchk("status", 8'h2A, 8'h30);
    apb(1, 8'h2A, 8'h80);
    rchk("cleared", 8'h28, 8'h00);
    rchk("rst_bit", 8'h2A, 8'hB0);
    apb(1, 8'h2A, 8'h00);
    @(posedge clk_sys_i) step_pulse_i <= 1;
    repeat (65536) @(posedge clk_sys_i);
    step_pulse_i <= 0;
    repeat (3) @(posedge clk_sys_i);
    rchk("sat_lo", 8'h28, 8'hFF);
    rchk("sat_hi", 8'h29, 8'hFF);
    rchk("ovf", 8'h2A, 8'h38);
    apb(1, 8'h2A, 8'h80);
    apb(1, 8'h2A, 8'h00);
    rchk("ovf_clr", 8'h2A, 8'h30);
    rchk("hi_clr", 8'h29, 8'h00);
    // Steps keep coming through the read, so the flag stands at setup
    @(posedge clk_sys_i) step_pulse_i <= 1;
    rchk("inc_flag", 8'h2A, 8'h34);
    step_pulse_i <= 0;
    apb(1, 8'hAA, 8'h01);
    @(posedge clk_sys_i) step_pulse_i <= 1;
    rchk("inc_held", 8'h2A, 8'h30);
    step_pulse_i <= 0;
    rchk("count_six", 8'h28, 8'h06);
    apb(1, 8'h2C, 8'hB8);
    rchk("init", 8'h2C, 8'h00);
    apb(0, 8'h30, 8'h00);
    chk("slverr", 8'h01, {7'h00, er});
    chk("unmapped", 8'h00, rd);
    chk("pready", 8'h01, {7'h00, pready_o});
    final_report();
  end
endmodule // tb_top
